// ==== hdl/rtr_device.sv ====
// Device end: test register bank with power-on and manual reset sequencing.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtr_device #(
  parameter int POR_CYCLES = rtr_pkg::DEV_POR_CYCLES,
  parameter int MAN_RECOVER_CYCLES = rtr_pkg::DEV_MAN_RECOVER_CYCLES,
  parameter int CLOCK_OUTPUT_PIN_HALF = rtr_pkg::CLOCK_OUTPUT_PIN_HALF,
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  rtr_link_if.dev link,
  output logic boost_stage_one,
  output logic boost_stage_two,
  output logic lna_high_sens,
  output logic [7:0] fading_gain_setting,
  output logic low_index_correction_enable,
  output logic [16:0] freq_offset_hz,
  output logic device_ready
);

  // Synchronisers for every pin; stage zero feeds stage one only.
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [1:0] nss_s;
  logic [1:0] rst_s;
  // Delayed copy of the synchronised clock for edge detection.
  logic sck_d;

  // Reset sequencing state.
  logic [CNT_W-1:0] por_cnt;
  logic por_done;
  logic [CNT_W-1:0] man_cnt;
  logic man_busy;
  logic busy;

  // Serial frame state.
  logic [4:0] bit_cnt;
  logic [14:0] shift_in;
  logic [7:0] miso_shift;
  logic sck_rise;
  logic sck_fall;
  logic frame_on;
  logic wr_strobe;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;

  // The register bank itself.
  logic [7:0] lna_sensitivity;
  logic [7:0] boost_amp_trim_one;
  logic [7:0] boost_amp_trim_two;
  logic [7:0] fading_gain_control;
  logic [7:0] low_index_freq_offset;
  logic [7:0] low_index_ctrl;

  // Clock output divider.
  logic [CNT_W-1:0] ck_cnt;
  logic ck_level;

  // Read multiplexer; unmapped addresses return zero.
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      rtr_pkg::ADDR_LNA: v = lna_sensitivity;
      rtr_pkg::ADDR_PA1: v = boost_amp_trim_one;
      rtr_pkg::ADDR_PA2: v = boost_amp_trim_two;
      rtr_pkg::ADDR_DAGC: v = fading_gain_control;
      rtr_pkg::ADDR_AFC: v = low_index_freq_offset;
      rtr_pkg::ADDR_LI_CTRL: v = low_index_ctrl;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Pins come from another party's clock, so each passes two flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s <= 2'h0;
      mosi_s <= 2'h0;
      nss_s <= 2'h3;
      rst_s <= 2'h0;
      sck_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], link.sck};
      mosi_s <= {mosi_s[0], link.mosi};
      nss_s <= {nss_s[0], link.nss_n};
      rst_s <= {rst_s[0], link.reset_pin};
      sck_d <= sck_s[1];
    end
  end

  // Power-on reset runs from supply power alone; no host action is needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      if (por_cnt == CNT_W'(POR_CYCLES - 1)) begin
        por_done <= 1'b1;
      end else begin
        por_cnt <= por_cnt + 1'b1;
      end
    end
  end

  // Manual reset holds while the pin is high and recovers after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_cnt <= '0;
      man_busy <= 1'b0;
    end else if (rst_s[1]) begin
      man_cnt <= '0;
      man_busy <= 1'b1;
    end else if (man_busy) begin
      if (man_cnt == CNT_W'(MAN_RECOVER_CYCLES - 1)) begin
        man_busy <= 1'b0;
      end else begin
        man_cnt <= man_cnt + 1'b1;
      end
    end
  end

  // Any reset source keeps the device away from the link.
  assign busy = !por_done || man_busy || rst_s[1];

  // Edge detection only looks at the second synchroniser stage.
  assign sck_rise = sck_s[1] && !sck_d;
  assign sck_fall = !sck_s[1] && sck_d;
  assign frame_on = !busy && !nss_s[1];
  // Address is complete on the eighth rising edge.
  assign rd_addr = {shift_in[5:0], mosi_s[1]};
  // Write fields as they stand on the sixteenth rising edge.
  assign wr_addr = shift_in[13:7];
  assign wr_data = {shift_in[6:0], mosi_s[1]};
  assign wr_strobe = frame_on && sck_rise && (bit_cnt == 5'(rtr_pkg::FRAME_BITS - 1))
                     && shift_in[rtr_pkg::FRAME_WR_BIT - 1];

  // Incoming shift register; a deselect or a reset drops a partial frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 5'h00;
      shift_in <= 15'h0000;
    end else if (!frame_on) begin
      bit_cnt <= 5'h00;
      shift_in <= 15'h0000;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 5'h01;
      shift_in <= {shift_in[13:0], mosi_s[1]};
    end
  end

  // Outgoing read data is loaded once the address is known.
  // Changing on the falling edge gives the host half a period of margin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_shift <= 8'h00;
      link.miso <= 1'b0;
    end else if (!frame_on) begin
      miso_shift <= 8'h00;
      link.miso <= 1'b0;
    end else if (sck_rise && bit_cnt == 5'h07) begin
      miso_shift <= read_reg(rd_addr);
    end else if (sck_fall && bit_cnt >= 5'h08) begin
      link.miso <= miso_shift[7];
      miso_shift <= {miso_shift[6:0], 1'b0};
    end
  end

  // Register bank; reset values are forced while any reset is active.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lna_sensitivity <= rtr_pkg::RST_LNA;
      boost_amp_trim_one <= rtr_pkg::RST_PA1;
      boost_amp_trim_two <= rtr_pkg::RST_PA2;
      fading_gain_control <= rtr_pkg::RST_DAGC;
      low_index_freq_offset <= rtr_pkg::RST_AFC;
      low_index_ctrl <= rtr_pkg::RST_LI_CTRL;
    end else if (busy) begin
      lna_sensitivity <= rtr_pkg::RST_LNA;
      boost_amp_trim_one <= rtr_pkg::RST_PA1;
      boost_amp_trim_two <= rtr_pkg::RST_PA2;
      fading_gain_control <= rtr_pkg::RST_DAGC;
      low_index_freq_offset <= rtr_pkg::RST_AFC;
      low_index_ctrl <= rtr_pkg::RST_LI_CTRL;
    end else if (wr_strobe) begin
      case (wr_addr)
        rtr_pkg::ADDR_LNA: lna_sensitivity <= wr_data;
        rtr_pkg::ADDR_PA1: boost_amp_trim_one <= wr_data;
        rtr_pkg::ADDR_PA2: boost_amp_trim_two <= wr_data;
        rtr_pkg::ADDR_DAGC: begin
          // Undefined gain codes are dropped so the loop never runs unspecified.
          if (wr_data == rtr_pkg::DAGC_NORMAL || wr_data == rtr_pkg::DAGC_LOWIDX
              || wr_data == rtr_pkg::DAGC_NOLOWIDX) begin
            fading_gain_control <= wr_data;
          end
        end
        rtr_pkg::ADDR_AFC: low_index_freq_offset <= wr_data;
        rtr_pkg::ADDR_LI_CTRL: low_index_ctrl <= wr_data;
        default: begin
          // Writes to unmapped addresses have no effect.
        end
      endcase
    end
  end

  // Decoded controls for the radio, registered so they change cleanly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_stage_one <= 1'b0;
      boost_stage_two <= 1'b0;
      lna_high_sens <= 1'b0;
      fading_gain_setting <= rtr_pkg::RST_DAGC;
      low_index_correction_enable <= 1'b0;
      freq_offset_hz <= 17'h00000;
      device_ready <= 1'b0;
    end else begin
      boost_stage_one <= (boost_amp_trim_one == rtr_pkg::PA1_BOOST);
      boost_stage_two <= (boost_amp_trim_two == rtr_pkg::PA2_BOOST);
      lna_high_sens <= (lna_sensitivity == rtr_pkg::LNA_HIGH);
      fading_gain_setting <= fading_gain_control;
      low_index_correction_enable <= low_index_ctrl[rtr_pkg::LI_EN_BIT];
      // The offset is unsigned here; it reaches 124440 Hz at most.
      if (low_index_ctrl[rtr_pkg::LI_EN_BIT]) begin
        freq_offset_hz <= 17'(low_index_freq_offset) * 17'(rtr_pkg::FREQ_STEP_HZ);
      end else begin
        freq_offset_hz <= 17'h00000;
      end
      device_ready <= !busy;
    end
  end

  // Clock output stays low in reset and toggles once the device is ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_cnt <= '0;
      ck_level <= 1'b0;
    end else if (busy) begin
      ck_cnt <= '0;
      ck_level <= 1'b0;
    end else if (ck_cnt == CNT_W'(CLOCK_OUTPUT_PIN_HALF - 1)) begin
      ck_cnt <= '0;
      ck_level <= !ck_level;
    end else begin
      ck_cnt <= ck_cnt + 1'b1;
    end
  end

  assign link.clock_output_pin = ck_level;

endmodule
`default_nettype wire

// ==== hdl/rtr_pkg.sv ====
// Shared constants for the radio test register bank and its host controller.
package rtr_pkg;
  // Device register addresses on the serial link.
  localparam logic [6:0] ADDR_LNA = 7'h58;
  localparam logic [6:0] ADDR_PA1 = 7'h5A;
  localparam logic [6:0] ADDR_PA2 = 7'h5C;
  localparam logic [6:0] ADDR_DAGC = 7'h6F;
  localparam logic [6:0] ADDR_AFC = 7'h71;
  localparam logic [6:0] ADDR_LI_CTRL = 7'h7E;
  // Reset values of the device registers.
  localparam logic [7:0] RST_LNA = 8'h1B;
  localparam logic [7:0] RST_PA1 = 8'h55;
  localparam logic [7:0] RST_PA2 = 8'h70;
  localparam logic [7:0] RST_DAGC = 8'h30;
  localparam logic [7:0] RST_AFC = 8'h00;
  localparam logic [7:0] RST_LI_CTRL = 8'h00;
  // Mode codes.
  localparam logic [7:0] LNA_HIGH = 8'h2D;
  localparam logic [7:0] PA1_BOOST = 8'h5D;
  localparam logic [7:0] PA2_BOOST = 8'h7C;
  localparam logic [7:0] DAGC_NORMAL = 8'h00;
  localparam logic [7:0] DAGC_LOWIDX = 8'h20;
  localparam logic [7:0] DAGC_NOLOWIDX = 8'h30;
  // Bit position of the low-index correction enable in its control register.
  localparam int LI_EN_BIT = 0;
  // Frequency step of the low-index offset, in hertz.
  localparam int FREQ_STEP_HZ = 488;
  // Clock rate and host-side waits.
  localparam int CLK_KHZ = 125000;
  localparam int POR_WAIT_MS = 10;
  localparam int POR_WAIT_CYCLES = POR_WAIT_MS * CLK_KHZ;
  localparam int MAN_WAIT_MS = 5;
  localparam int MAN_WAIT_CYCLES = MAN_WAIT_MS * CLK_KHZ;
  localparam int MAN_PULSE_US = 100;
  localparam int MAN_PULSE_CYCLES = (MAN_PULSE_US * CLK_KHZ) / 1000;
  // Device-internal reset lengths and link timing.
  localparam int DEV_POR_CYCLES = 1000;
  localparam int DEV_MAN_RECOVER_CYCLES = 500;
  localparam int CLOCK_OUTPUT_PIN_HALF = 4;
  localparam int SPI_HALF = 8;
  // Serial frame layout: write flag, seven address bits, eight data bits.
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WR_BIT = 15;
  // Host APB register offsets.
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RESET = 8'h08;
  localparam logic [7:0] APB_MODE = 8'h0C;
  // Host APB field positions.
  localparam int CMD_WR_BIT = 16;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_RESET_BIT = 2;
  localparam int MODE_BOOST_BIT = 0;
  localparam int MODE_LI_BIT = 1;
  localparam int MODE_STEPS = 4;
endpackage

// ==== hdl/rtr_link_if.sv ====
// Serial link and reset wiring between the host controller and the device.
`timescale 1ns/1ps
`default_nettype none
interface rtr_link_if;
  logic sck;              // Serial clock from the host.
  logic mosi;             // Host to device data.
  logic miso;             // Device to host data.
  logic nss_n;            // Frame select, active low.
  logic reset_out;        // Level the host puts on the reset pin.
  logic reset_oe_n;       // Host drive enable for the reset pin, active low.
  logic reset_pin;        // Resolved reset pin level.
  logic clock_output_pin; // Device clock output, toggles once ready.

  // An undriven reset pin is pulled low inside the device.
  assign reset_pin = (!reset_oe_n) ? reset_out : 1'b0;

  modport host (
    output sck, mosi, nss_n, reset_out, reset_oe_n,
    input miso, clock_output_pin
  );
  modport dev (
    input sck, mosi, nss_n, reset_pin,
    output miso, clock_output_pin
  );
endinterface
`default_nettype wire

// ==== hdl/rtr_host.sv ====
// Host end: APB-controlled controller that sequences reset and drives the serial link.
`timescale 1ns/1ps
`default_nettype none
module rtr_host #(
  parameter int POR_WAIT = rtr_pkg::POR_WAIT_CYCLES,
  parameter int MAN_PULSE = rtr_pkg::MAN_PULSE_CYCLES,
  parameter int MAN_WAIT = rtr_pkg::MAN_WAIT_CYCLES,
  parameter int SPI_HALF = rtr_pkg::SPI_HALF,
  parameter int CNT_W = 21
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rtr_link_if.host link
);

  typedef enum {ST_POR_WAIT, ST_PULSE, ST_RST_WAIT, ST_READY, ST_XFER} rtr_state_t;
  rtr_state_t state;

  logic [CNT_W-1:0] wait_cnt; // Reset wait and pulse counter.
  logic [7:0] div_cnt;        // Serial clock half-period counter.
  logic [4:0] bit_cnt;        // Bits sent in the current frame.
  logic [15:0] tx;            // Outgoing frame, sent from the top.
  logic [7:0] rx;             // Incoming bits; the last eight are the data.
  logic [7:0] rd_data;        // Data of the last completed frame.
  logic [1:0] ck_s;           // Clock output synchroniser.
  logic ck_d;
  logic [1:0] mi_s;           // Read data synchroniser.
  logic ck_edge;
  logic cmd_req;              // A software frame waits to be sent.
  logic [15:0] cmd_frame;
  logic reset_req;            // A manual reset waits to be issued.
  logic [2:0] mode_left;      // Mode writes still to send.
  logic [1:0] mode;           // Boost and low-index selection.
  logic apb_wr;
  logic tick;
  logic done;
  logic launch;

  // Frame of each automatic mode write, counted down from the first.
  function automatic logic [15:0] mode_frame(input logic [2:0] left, input logic [1:0] m);
    logic [15:0] f;
    f = 16'h0000;
    case (left)
      3'h4: f = {1'b1, rtr_pkg::ADDR_PA1,
                 m[rtr_pkg::MODE_BOOST_BIT] ? rtr_pkg::PA1_BOOST : rtr_pkg::RST_PA1};
      3'h3: f = {1'b1, rtr_pkg::ADDR_PA2,
                 m[rtr_pkg::MODE_BOOST_BIT] ? rtr_pkg::PA2_BOOST : rtr_pkg::RST_PA2};
      3'h2: f = {1'b1, rtr_pkg::ADDR_LI_CTRL, 7'h00, m[rtr_pkg::MODE_LI_BIT]};
      3'h1: f = {1'b1, rtr_pkg::ADDR_DAGC,
                 m[rtr_pkg::MODE_LI_BIT] ? rtr_pkg::DAGC_LOWIDX : rtr_pkg::DAGC_NOLOWIDX};
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign ck_edge = ck_s[1] ^ ck_d;
  assign tick = (div_cnt == 8'(SPI_HALF - 1));
  assign done = (state == ST_XFER) && tick && link.sck && (bit_cnt == 5'h0F);
  assign launch = (state == ST_READY) && !reset_req && (mode_left != 3'h0 || cmd_req);
  assign link.reset_out = 1'b1;

  // Pins from the device pass two flip-flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s <= 2'h0;
      ck_d <= 1'b0;
      mi_s <= 2'h0;
    end else begin
      ck_s <= {ck_s[0], link.clock_output_pin};
      ck_d <= ck_s[1];
      mi_s <= {mi_s[0], link.miso};
    end
  end

  // Software requests; a launch or pulse start consumes them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_req <= 1'b0;
      cmd_frame <= 16'h0000;
      reset_req <= 1'b0;
      mode_left <= 3'h0;
      mode <= 2'h0;
    end else begin
      if (apb_wr && paddr == rtr_pkg::APB_CMD && !cmd_req) begin
        cmd_req <= 1'b1;
        // The write flag sits one bit above the address byte in the command word.
        cmd_frame <= {pwdata[rtr_pkg::CMD_WR_BIT], pwdata[14:0]};
      end else if (launch && mode_left == 3'h0) begin
        cmd_req <= 1'b0;
      end
      if (apb_wr && paddr == rtr_pkg::APB_RESET && pwdata[0]) begin
        reset_req <= 1'b1;
      end else if (state == ST_READY) begin
        reset_req <= 1'b0;
      end
      if (apb_wr && paddr == rtr_pkg::APB_MODE) begin
        mode <= pwdata[1:0];
        mode_left <= 3'(rtr_pkg::MODE_STEPS);
      end else if (launch && mode_left != 3'h0) begin
        mode_left <= mode_left - 3'h1;
      end
    end
  end

  // Link sequencing: reset waits, pulse, idle and frame transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_POR_WAIT;
      wait_cnt <= '0;
      link.reset_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_POR_WAIT: begin
          // The pin stays released; a clock output edge ends the wait early.
          if (ck_edge || wait_cnt == CNT_W'(POR_WAIT - 1)) begin
            state <= ST_READY;
            wait_cnt <= '0;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        ST_PULSE: begin
          if (wait_cnt == CNT_W'(MAN_PULSE - 1)) begin
            state <= ST_RST_WAIT;
            wait_cnt <= '0;
            link.reset_oe_n <= 1'b1;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        ST_RST_WAIT: begin
          if (ck_edge || wait_cnt == CNT_W'(MAN_WAIT - 1)) begin
            state <= ST_READY;
            wait_cnt <= '0;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        ST_READY: begin
          if (reset_req) begin
            state <= ST_PULSE;
            link.reset_oe_n <= 1'b0;
          end else if (launch) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (done) begin
            state <= ST_READY;
          end
        end
        default: state <= ST_POR_WAIT;
      endcase
    end
  end

  // Serial shifting; the clock idles low and data changes on falling edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      tx <= 16'h0000;
      rx <= 8'h00;
      rd_data <= 8'h00;
      link.sck <= 1'b0;
      link.nss_n <= 1'b1;
    end else if (launch) begin
      div_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      tx <= (mode_left != 3'h0) ? mode_frame(mode_left, mode) : cmd_frame;
      link.nss_n <= 1'b0;
    end else if (state == ST_XFER) begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      if (tick) begin
        link.sck <= !link.sck;
        if (!link.sck) begin
          rx <= {rx[6:0], mi_s[1]};
        end else begin
          tx <= {tx[14:0], 1'b0};
          bit_cnt <= bit_cnt + 5'h01;
          if (done) begin
            link.nss_n <= 1'b1;
            rd_data <= rx;
          end
        end
      end
    end
  end

  assign link.mosi = tx[15];

  // Read data is loaded in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        rtr_pkg::APB_STATUS: begin
          prdata <= 32'h00000000;
          prdata[rtr_pkg::STAT_READY_BIT] <= (state == ST_READY);
          prdata[rtr_pkg::STAT_BUSY_BIT] <= (state == ST_XFER) || cmd_req || (mode_left != 3'h0);
          prdata[rtr_pkg::STAT_RESET_BIT] <= (state == ST_PULSE) || (state == ST_RST_WAIT)
                                             || (state == ST_POR_WAIT);
          prdata[15:8] <= rd_data;
        end
        rtr_pkg::APB_MODE: prdata <= {30'h00000000, mode};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== sim/rtr_sva.sv ====
// Concurrent checks on the serial link and reset pin between host and device.
`timescale 1ns/1ps
`default_nettype none
module rtr_sva #(
  parameter int POR_CYCLES = 100,
  parameter int MAN_PULSE = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic miso,
  input wire logic nss_n,
  input wire logic reset_out,
  input wire logic reset_oe_n,
  input wire logic reset_pin,
  input wire logic clock_output_pin
);
  int unsigned por_cnt; // Cycles since reset release, saturating so it never wraps.
  int unsigned pulse_cnt; // Length of the present drive on the reset pin.

  // Counts up from reset release so the clock output can be tied to it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_cnt <= 0;
    else if (por_cnt < 100000) por_cnt <= por_cnt + 1;
  end

  // Counts the cycles of one reset pin drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_cnt <= 0;
    else pulse_cnt <= reset_oe_n ? 0 : pulse_cnt + 1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clk_low;
    !clock_output_pin [*4];
  endsequence

  a_pin_drive_high:
    assert property (!reset_oe_n |-> reset_pin && reset_out) else $error("reset pin not high");
  a_pulse_length:
    assert property ($rose(reset_oe_n) |-> pulse_cnt inside {[MAN_PULSE-1:MAN_PULSE+1]})
    else $error("reset pulse length wrong");
  a_quiet_after_pulse:
    assert property ($rose(reset_oe_n) |-> nss_n [*8]) else $error("frame too soon");
  a_no_frame_reset:
    assert property (!reset_oe_n |-> nss_n) else $error("frame during reset drive");
  a_clock_output_pin_held:
    assert property (reset_pin [*5] |-> !clock_output_pin) else $error("clock out in reset");
  a_clock_output_pin_period:
    assert property ($fell(clock_output_pin) |-> s_clk_low) else $error("clock out half wrong");
  a_por_silent:
    assert property (clock_output_pin |-> por_cnt > POR_CYCLES) else $error("clock out too early");
  a_pin_free_por:
    assert property (por_cnt <= POR_CYCLES |-> reset_oe_n)
    else $error("reset pin driven during power-on");
  a_quiet_in_por:
    assert property (por_cnt <= POR_CYCLES |-> nss_n) else $error("frame during power-on");
  a_link_idle:
    // The device sees a deselect through two flip-flops, so its data pin lags by three cycles.
    assert property (nss_n [*4] |-> !sck && !miso) else $error("link busy when idle");
endmodule
`default_nettype wire

// ==== sim/test_radio_test_regs_and_reset_sequencing.sv ====
// Bench joining host and device ends, driving APB with random and corner values.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_radio_test_regs_and_reset_sequencing;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic boost_stage_one, boost_stage_two, lna_high_sens, li_en, device_ready;
  logic [7:0] gain;
  logic [16:0] freq_offset_hz;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] r;
  logic [7:0] v;
  logic [7:0] codes [3] = '{rtr_pkg::DAGC_NORMAL, rtr_pkg::DAGC_LOWIDX, rtr_pkg::DAGC_NOLOWIDX};

  rtr_link_if link ();
  // Long waits are shortened so the run stays brief.
  rtr_host #(.POR_WAIT(2000), .MAN_PULSE(50), .MAN_WAIT(2000)) i_rtr_host (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  rtr_device #(.POR_CYCLES(100), .MAN_RECOVER_CYCLES(50)) i_rtr_device (.pclk(pclk),
    .presetn(presetn), .link(link), .boost_stage_one(boost_stage_one),
    .boost_stage_two(boost_stage_two), .lna_high_sens(lna_high_sens),
    .fading_gain_setting(gain), .low_index_correction_enable(li_en),
    .freq_offset_hz(freq_offset_hz), .device_ready(device_ready));
  // The checker's default timing already matches the shortened device and host above.
  rtr_sva i_rtr_sva (.pclk(pclk), .presetn(presetn),
    .sck(link.sck), .miso(link.miso), .nss_n(link.nss_n), .reset_out(link.reset_out),
    .reset_oe_n(link.reset_oe_n), .reset_pin(link.reset_pin),
    .clock_output_pin(link.clock_output_pin));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 pclk = ~pclk;
  end

  // Expected offset: register times the step, only while correction is on.
  function automatic logic [16:0] exp_offset(input logic [7:0] val, input logic en);
    return en ? 17'(val * rtr_pkg::FREQ_STEP_HZ) : 17'h0;
  endfunction

  // Prints the verdict and ends the run; shared by the tests and the watchdog.
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait length is assumed; only the watchdog ends a wait that never finishes.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls status until the host is ready and idle; a stuck host counts as a mismatch.
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    repeat (2) @(posedge pclk);
    n = 0;
    do begin
      apb(1'b0, rtr_pkg::APB_STATUS, 32'h0, s);
      n++;
    end while ((s[1] !== 1'b0 || s[0] !== 1'b1) && n < 3000);
    if (n >= 3000) miscompares++;
    repeat (4) @(posedge pclk);
  endtask

  // Sends one device register frame through the command register.
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
    apb(1'b1, rtr_pkg::APB_CMD, {15'h0, w, 1'b0, a, d}, r);
    wait_idle();
  endtask

  // Waits a bounded time for the device ready flag to reach a level.
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (device_ready !== lvl && n < 5000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  initial begin
    void'($urandom(60));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready(1'b1);
    `CHK(device_ready, 1'b1)
    `CHK(boost_stage_one, 1'b0)
    `CHK(boost_stage_two, 1'b0)
    `CHK(gain, rtr_pkg::RST_DAGC)
    wait_idle();
    cmd(1'b1, rtr_pkg::ADDR_PA1, rtr_pkg::PA1_BOOST);
    `CHK(boost_stage_one, 1'b1)
    cmd(1'b1, rtr_pkg::ADDR_PA2, rtr_pkg::PA2_BOOST);
    `CHK(boost_stage_two, 1'b1)
    cmd(1'b0, rtr_pkg::ADDR_PA1, 8'h00);
    apb(1'b0, rtr_pkg::APB_STATUS, 32'h0, r);
    `CHK(r[15:8], rtr_pkg::PA1_BOOST)
    cmd(1'b1, rtr_pkg::ADDR_PA1, rtr_pkg::RST_PA1);
    `CHK(boost_stage_one, 1'b0)
    cmd(1'b1, rtr_pkg::ADDR_PA2, rtr_pkg::RST_PA2);
    `CHK(boost_stage_two, 1'b0)
    cmd(1'b1, rtr_pkg::ADDR_LNA, rtr_pkg::LNA_HIGH);
    `CHK(lna_high_sens, 1'b1)
    cmd(1'b1, rtr_pkg::ADDR_LNA, rtr_pkg::RST_LNA);
    `CHK(lna_high_sens, 1'b0)
    // Every gain code, then a random illegal code that must leave the last one.
    foreach (codes[i]) begin
      cmd(1'b1, rtr_pkg::ADDR_DAGC, codes[i]);
      `CHK(gain, codes[i])
    end
    do v = 8'($urandom); while (v inside {8'h00, 8'h20, 8'h30});
    cmd(1'b1, rtr_pkg::ADDR_DAGC, v);
    `CHK(gain, rtr_pkg::DAGC_NOLOWIDX)
    v = 8'($urandom);
    cmd(1'b1, rtr_pkg::ADDR_AFC, v);
    cmd(1'b1, rtr_pkg::ADDR_LI_CTRL, 8'h01);
    `CHK(freq_offset_hz, exp_offset(v, 1'b1))
    `CHK(li_en, 1'b1)
    cmd(1'b1, rtr_pkg::ADDR_LI_CTRL, 8'h00);
    `CHK(freq_offset_hz, exp_offset(v, 1'b0))
    `CHK(li_en, 1'b0)
    // Every mode pairing of boost and low-index correction.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, rtr_pkg::APB_MODE, 32'(m), r);
      wait_idle();
      `CHK(boost_stage_two, m[0])
      `CHK(gain, m[1] ? rtr_pkg::DAGC_LOWIDX : rtr_pkg::DAGC_NOLOWIDX)
      apb(1'b0, rtr_pkg::APB_MODE, 32'h0, r);
      `CHK(r, 32'(m))
    end
    // Manual reset must bring the first boost stage and the gain back to their reset values.
    apb(1'b1, rtr_pkg::APB_RESET, 32'h1, r);
    wait_ready(1'b0);
    `CHK(device_ready, 1'b0)
    wait_idle();
    `CHK(boost_stage_one, 1'b0)
    `CHK(gain, rtr_pkg::RST_DAGC)
    `CHK(device_ready, 1'b1)
    apb(1'b0, 8'h10, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(pslverr, 1'b0)
    report_and_stop();
  end

  // Watchdog: the tests need about 8000 cycles, so 40000 leaves ample margin.
  initial begin
    #(8 * 40000);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
